// *** shared/rail_seq_pkg.sv ***
package rail_seq_pkg;
   // --------
   // clock and timing
   // --------
   localparam int unsigned CLK_PERIOD_NS   = 100;
   localparam int unsigned RESET_PERIOD_MS = 180;
   localparam int unsigned SS_TIME_US      = 1300;
   localparam int unsigned SS_GAP_MS       = 1;
   localparam int unsigned SS_DISCH_US     = 500;
   localparam int unsigned HICCUP_MS       = 10;
   localparam int unsigned SW_CYCLE_NS     = 2000;
   localparam int unsigned RESET_CYC_DEF   = (RESET_PERIOD_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned SPACE_CYC_DEF   = ((SS_TIME_US + SS_GAP_MS * 1000) * 1000 + CLK_PERIOD_NS - 1)
                                             / CLK_PERIOD_NS;
   localparam int unsigned DISCH_CYC_DEF   = (SS_DISCH_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned HICCUP_CYC_DEF  = (HICCUP_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned SW_DIV          = SW_CYCLE_NS / CLK_PERIOD_NS;
   localparam int unsigned CNT_W           = 24;
   localparam int unsigned DIV_W           = 8;

   // --------
   // over-current blanking
   // --------
   localparam logic [4:0]  BLANK_FIRST     = 5'h01;
   localparam logic [4:0]  BLANK_MAX       = 5'h10;

   // --------
   // register map
   // --------
   localparam int unsigned ADDR_W          = 4;
   localparam int unsigned DATA_W          = 8;
   localparam logic [3:0]  ADDR_ENABLE     = 4'h0;
   localparam logic [3:0]  ADDR_STATUS     = 4'h1;
   localparam logic [3:0]  ADDR_STATE      = 4'h2;
   localparam int unsigned EN_USB0_BIT     = 0;
   localparam int unsigned EN_BUCK0_BIT    = 2;
   localparam int unsigned ST_BROWNOUT_BIT = 0;
   localparam int unsigned ST_HOT_BIT      = 1;
   localparam int unsigned ST_UNDERVOLTAGE_LOCKOUT_BIT     = 2;
   localparam int unsigned ST_WARN_BIT     = 3;
   localparam int unsigned ST_USBF0_BIT    = 4;
   localparam logic [7:0]  ENABLE_RESET    = 8'h00;
   localparam logic [2:0]  STATUS_RESET    = 3'h0;

   typedef enum logic [1:0] {
      SEQ_IDLE,
      SEQ_DISCHARGE,
      SEQ_RAMP
   } seq_state_t;
endpackage : rail_seq_pkg

// *** rtl/sync_bank.sv ***
module sync_bank
#(
   parameter int unsigned WIDTH = 1
)
(
   input  wire logic             clk,
   input  wire logic             rst,
   input  wire logic [WIDTH-1:0] async_in,
   output logic      [WIDTH-1:0] sync_out
);
   // --------
   // two-stage synchroniser, first stage read only by the second
   // --------
   logic [WIDTH-1:0] meta_q;

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         meta_q   <= '0;
         sync_out <= '0;
      end else begin
         meta_q   <= async_in;
         sync_out <= meta_q;
      end
   end
endmodule : sync_bank

// *** rtl/rail_sequencing_fault_control.sv ***
// Function
// RULE_01 - any monitor input below threshold holds supervisor reset low at least 180 ms
// RULE_02 - supervisor reset never touches regulators or usb switches
// RULE_03 - usb switch follows its pin in pin mode, its enable bit in serial mode
// RULE_04 - usb fault output low while that switch is current limiting
// RULE_05 - thermal warning turns both usb switches off, recovery automatic
// RULE_06 - low enable keeps regulator off; enable starts it at once when none starting
// RULE_07 - simultaneous enables start in order one, two, three, spaced soft-start plus 1 ms
// RULE_08 - enables arriving during a start are served afterwards in default order
// RULE_09 - serial enable bit starts a regulator under the same arbitration as pins
// RULE_10 - over-current sampled each switching cycle; next cycle suppressed on detection
// RULE_11 - consecutive detections double suppressed cycles 1,2,4,8, saturating at 16
// RULE_12 - after over-current shutdown hold converter off a fixed time, then retry
// RULE_13 - shared soft-start discharged and restarted before each regulator start
// RULE_14 - warning low below 9.3 V, released for brownout only above 10.8 V
// RULE_15 - warning also low while chip is above the hot threshold
// RULE_16 - brownout and overtemperature set separate flags in the first status register
// RULE_17 - status reads never affect the warning output
// RULE_18 - usb switches off when main below 9.3 V or usb input low while enabled
// RULE_19 - all regulators off when main below 4.7 V or regulator input low with two/three on
// RULE_20 - lockout does not latch; buck enable inputs discharged during lockout
// RULE_21 - serial mode lockout clears all enable bits and raises host interrupt
// RULE_22 - host re-sets regulator bits or pins, and rewrites usb bits after lockout
// RULE_23 - all comparator results synchronised before use
//
// The register offsets and the plain strobed port are this design's own decisions.
module rail_sequencing_fault_control
   import rail_seq_pkg::*;
#(
   parameter int unsigned RESET_CYC  = RESET_CYC_DEF,
   parameter int unsigned SPACE_CYC  = SPACE_CYC_DEF,
   parameter int unsigned DISCH_CYC  = DISCH_CYC_DEF,
   parameter int unsigned HICCUP_CYC = HICCUP_CYC_DEF
)
(
   input  wire logic              clk,
   input  wire logic              rst,
   input  wire logic              monitor_input_one_low,
   input  wire logic              monitor_input_two_low,
   input  wire logic              main_below_9v3,
   input  wire logic              main_above_10v8,
   input  wire logic              main_below_4v7,
   input  wire logic              regulator_input_below_4v25,
   input  wire logic              usb_input_below_3v9,
   input  wire logic              chip_hot,
   input  wire logic              serial_mode,
   input  wire logic [1:0]        usb_enable_pin,
   input  wire logic [1:0]        usb_current_limit,
   input  wire logic [2:0]        regulator_enable_pin,
   input  wire logic [2:0]        buck_overcurrent,
   input  wire logic [2:0]        buck_output_undervoltage,
   input  wire logic [ADDR_W-1:0] addr,
   input  wire logic [DATA_W-1:0] wr_data,
   input  wire logic              wr_en,
   input  wire logic              rd_en,
   output logic      [DATA_W-1:0] rd_data,
   output logic                   supply_supervisor_reset_n,
   output logic      [1:0]        usb_switch_on,
   output logic      [1:0]        usb_fault_output_n,
   output logic      [2:0]        buck_on,
   output logic      [2:0]        buck_high_side_enable,
   output logic                   soft_start_discharge,
   output logic                   regulator_enable_discharge,
   output logic                   supply_heat_warning_n,
   output logic                   host_irq
);
   // --------
   // parameter checks
   // --------
   if (RESET_CYC < 1 || RESET_CYC >= (1 << CNT_W)) $error("RESET_CYC out of range");
   if (SPACE_CYC < 1 || SPACE_CYC >= (1 << CNT_W)) $error("SPACE_CYC out of range");
   if (DISCH_CYC < 1 || DISCH_CYC >= (1 << CNT_W)) $error("DISCH_CYC out of range");
   if (HICCUP_CYC < 1 || HICCUP_CYC >= (1 << CNT_W)) $error("HICCUP_CYC out of range");

   // --------
   // input synchronisation
   // --------
   localparam int unsigned NSYNC = 22;
   logic [NSYNC-1:0] raw_in;
   logic [NSYNC-1:0] sync_in;
   logic             mon1_low;
   logic             mon2_low;
   logic             vin_lt_9v3;
   logic             vin_gt_10v8;
   logic             vin_lt_4v7;
   logic             regulator_input_supply_low;
   logic             usb_input_supply_low;
   logic             hot;
   logic             serial_s;
   logic [1:0]       usb_pin_s;
   logic [1:0]       usb_limit_s;
   logic [2:0]       reg_pin_s;
   logic [2:0]       oc_s;
   logic [2:0]       uv_s;

   assign raw_in = {monitor_input_one_low, monitor_input_two_low, main_below_9v3, main_above_10v8,
                    main_below_4v7, regulator_input_below_4v25, usb_input_below_3v9, chip_hot,
                    serial_mode, usb_enable_pin, usb_current_limit, regulator_enable_pin,
                    buck_overcurrent, buck_output_undervoltage};

   sync_bank #(.WIDTH(NSYNC)) u_sync ( // [RULE_23]
      .clk      (clk),
      .rst      (rst),
      .async_in (raw_in),
      .sync_out (sync_in)
   );

   assign {mon1_low, mon2_low, vin_lt_9v3, vin_gt_10v8, vin_lt_4v7, regulator_input_supply_low, usb_input_supply_low, hot,
           serial_s, usb_pin_s, usb_limit_s, reg_pin_s, oc_s, uv_s} = sync_in;

   // --------
   // supply supervisor reset
   // --------
   // the counter reloads while any input is low, so the pulse is measured from the last dip
   logic [CNT_W-1:0] svs_cnt_q;

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         svs_cnt_q                 <= '0;
         supply_supervisor_reset_n <= 1'b0;
      end else begin
         if (mon1_low || mon2_low) begin
            svs_cnt_q                 <= CNT_W'(RESET_CYC); // [RULE_01]
            supply_supervisor_reset_n <= 1'b0;
         end else if (svs_cnt_q != '0) begin
            svs_cnt_q                 <= svs_cnt_q - 1'b1;
            supply_supervisor_reset_n <= 1'b0;
         end else begin
            supply_supervisor_reset_n <= 1'b1; // [RULE_01]
         end
      end
   end
   // the reset pulse feeds nothing below: rails and switches ignore it [RULE_02]

   // --------
   // lockout and warning
   // --------
   logic       brownout_q;
   logic       usb_lock;
   logic       buck_lock;
   logic       lock_q;
   logic       lock_event;
   logic [7:0] enable_q;
   logic [2:0] flags_q;

   assign usb_lock   = vin_lt_9v3 || (usb_input_supply_low && (usb_switch_on != 2'b00)); // [RULE_18]
   assign buck_lock  = vin_lt_4v7 || (regulator_input_supply_low && (buck_on[1] || buck_on[2])); // [RULE_19]
   assign lock_event = (usb_lock || buck_lock) && !lock_q;

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         brownout_q <= 1'b1;
      end else if (vin_lt_9v3) begin
         brownout_q <= 1'b1; // [RULE_14]
      end else if (vin_gt_10v8) begin
         brownout_q <= 1'b0; // [RULE_14]
      end
   end

   // depends only on the supply and temperature state, never on a bus access [RULE_17]
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         supply_heat_warning_n      <= 1'b0;
         regulator_enable_discharge <= 1'b0;
         lock_q                     <= 1'b0;
      end else begin
         supply_heat_warning_n      <= !(brownout_q || vin_lt_9v3 || hot); // [RULE_14] [RULE_15]
         regulator_enable_discharge <= buck_lock; // [RULE_20]
         lock_q                     <= usb_lock || buck_lock;
      end
   end

   // --------
   // usb switches
   // --------
   logic [1:0] usb_want;

   always_comb begin
      usb_want = serial_s ? enable_q[EN_USB0_BIT +: 2] : usb_pin_s; // [RULE_03]
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         usb_switch_on      <= 2'b00;
         usb_fault_output_n <= 2'b11;
      end else begin
         // lockout clears as soon as the supply is back, or for a low usb input once the switches are off, no latch [RULE_20]
         usb_switch_on      <= (hot || usb_lock) ? 2'b00 : usb_want; // [RULE_05] [RULE_18]
         usb_fault_output_n <= ~(usb_limit_s & usb_switch_on); // [RULE_04]
      end
   end

   // --------
   // switching-cycle divider and over-current blanking
   // --------
   logic [DIV_W-1:0] div_q;
   logic             sw_tick;
   logic [4:0]       blank_cnt_q [3];
   logic [4:0]       blank_len_q [3];

   assign sw_tick = (div_q == DIV_W'(SW_DIV - 1));

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         div_q <= '0;
      end else begin
         div_q <= sw_tick ? '0 : div_q + 1'b1;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         for (int i = 0; i < 3; i++) begin
            blank_cnt_q[i] <= '0;
            blank_len_q[i] <= BLANK_FIRST;
         end
         buck_high_side_enable <= 3'b000;
      end else begin
         for (int i = 0; i < 3; i++) begin
            if (!buck_on[i]) begin
               blank_cnt_q[i]           <= '0;
               blank_len_q[i]           <= BLANK_FIRST;
               buck_high_side_enable[i] <= 1'b0;
            end else if (sw_tick) begin
               if (blank_cnt_q[i] != '0) begin
                  blank_cnt_q[i]           <= blank_cnt_q[i] - 1'b1;
                  buck_high_side_enable[i] <= (blank_cnt_q[i] == 5'h01);
               end else if (oc_s[i]) begin
                  blank_cnt_q[i]           <= blank_len_q[i]; // [RULE_10]
                  blank_len_q[i]           <= (blank_len_q[i] == BLANK_MAX) ? BLANK_MAX
                                              : {blank_len_q[i][3:0], 1'b0}; // [RULE_11]
                  buck_high_side_enable[i] <= 1'b0; // [RULE_10]
               end else begin
                  blank_len_q[i]           <= BLANK_FIRST; // [RULE_11]
                  buck_high_side_enable[i] <= 1'b1;
               end
            end
         end
      end
   end

   // --------
   // hiccup hold-off
   // --------
   logic [CNT_W-1:0] hic_cnt_q [3];
   logic [2:0]       hic_busy;
   logic [2:0]       hic_trip;

   always_comb begin
      for (int i = 0; i < 3; i++) begin
         hic_busy[i] = (hic_cnt_q[i] != '0);
         hic_trip[i] = buck_on[i] && uv_s[i];
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         for (int i = 0; i < 3; i++) begin
            hic_cnt_q[i] <= '0;
         end
      end else begin
         for (int i = 0; i < 3; i++) begin
            if (hic_trip[i]) begin
               hic_cnt_q[i] <= CNT_W'(HICCUP_CYC); // [RULE_12]
            end else if (hic_busy[i]) begin
               hic_cnt_q[i] <= hic_cnt_q[i] - 1'b1; // retry follows via the sequencer [RULE_12]
            end
         end
      end
   end

   // --------
   // start-up sequencer
   // --------
   // one soft-start resource, so only one rail ramps at a time; late enables simply queue
   seq_state_t       seq_q;
   logic [CNT_W-1:0] seq_cnt_q;
   logic [1:0]       seq_sel_q;
   logic [2:0]       buck_want;
   logic [2:0]       buck_req;
   logic [1:0]       pick;

   always_comb begin
      // pins are held discharged during lockout, so they cannot request [RULE_20]
      buck_want = (reg_pin_s & {3{!buck_lock}}) | (serial_s ? enable_q[EN_BUCK0_BIT +: 3] : 3'b000); // [RULE_09]
      buck_req  = buck_want & ~buck_on & ~hic_busy & {3{!buck_lock}};
      pick      = buck_req[0] ? 2'd0 : (buck_req[1] ? 2'd1 : 2'd2); // [RULE_07] [RULE_08]
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         seq_q                <= SEQ_IDLE;
         seq_cnt_q            <= '0;
         seq_sel_q            <= 2'd0;
         soft_start_discharge <= 1'b0;
      end else begin
         unique case (seq_q)
            SEQ_IDLE: begin
               if (buck_req != 3'b000) begin
                  seq_q                <= SEQ_DISCHARGE; // [RULE_06]
                  seq_sel_q            <= pick; // [RULE_07]
                  seq_cnt_q            <= CNT_W'(DISCH_CYC);
                  soft_start_discharge <= 1'b1; // [RULE_13]
               end
            end
            SEQ_DISCHARGE: begin
               if (seq_cnt_q == CNT_W'(1)) begin
                  seq_q                <= SEQ_RAMP;
                  seq_cnt_q            <= CNT_W'(SPACE_CYC); // [RULE_07]
                  soft_start_discharge <= 1'b0; // [RULE_13]
               end else begin
                  seq_cnt_q <= seq_cnt_q - 1'b1;
               end
            end
            SEQ_RAMP: begin
               if (seq_cnt_q == CNT_W'(1)) begin
                  seq_q <= SEQ_IDLE; // [RULE_08]
               end else begin
                  seq_cnt_q <= seq_cnt_q - 1'b1;
               end
            end
         endcase
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         buck_on <= 3'b000;
      end else begin
         for (int i = 0; i < 3; i++) begin
            if (buck_lock || !buck_want[i] || hic_trip[i]) begin
               buck_on[i] <= 1'b0; // [RULE_06] [RULE_19] [RULE_12]
            end else if (seq_q == SEQ_DISCHARGE && seq_cnt_q == CNT_W'(1) && seq_sel_q == 2'(i)) begin
               buck_on[i] <= 1'b1; // [RULE_06]
            end
         end
      end
   end

   // --------
   // register bus
   // --------
   logic       status_rd;
   logic [2:0] flag_set;

   assign status_rd = rd_en && (addr == ADDR_STATUS);

   always_comb begin
      flag_set                  = 3'b000;
      flag_set[ST_BROWNOUT_BIT] = vin_lt_9v3; // [RULE_16]
      flag_set[ST_HOT_BIT]      = hot; // [RULE_16]
      flag_set[ST_UNDERVOLTAGE_LOCKOUT_BIT]     = serial_s && lock_event; // [RULE_21]
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         enable_q <= ENABLE_RESET;
      end else if (serial_s && lock_event) begin
         enable_q <= ENABLE_RESET; // [RULE_21] host must rewrite them [RULE_22]
      end else if (wr_en && addr == ADDR_ENABLE) begin
         enable_q <= {3'b000, wr_data[4:0]};
      end
   end

   // a flag raised in the same cycle as the clearing read survives
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         flags_q <= STATUS_RESET;
      end else begin
         flags_q <= (status_rd ? 3'b000 : flags_q) | flag_set;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         host_irq <= 1'b0;
      end else begin
         host_irq <= serial_s && ((flags_q != 3'b000) || (flag_set != 3'b000)); // [RULE_21]
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         rd_data <= '0;
      end else if (rd_en) begin
         unique case (addr)
            ADDR_ENABLE: rd_data <= enable_q;
            ADDR_STATUS: rd_data <= {2'b00, ~usb_fault_output_n, !supply_heat_warning_n, flags_q};
            ADDR_STATE:  rd_data <= {3'b000, buck_on, usb_switch_on};
            default:     rd_data <= '0;
         endcase
      end else begin
         rd_data <= '0;
      end
   end
endmodule : rail_sequencing_fault_control

// *** verif/rail_seq_monitor.sv ***
module rail_seq_monitor
   import rail_seq_pkg::*;
#(
   parameter int unsigned SPACE_CYC = 30,
   parameter int unsigned DISCH_CYC = 10
)
(
   input wire logic       clk,
   input wire logic       rst,
   input wire logic       main_below_9v3,
   input wire logic       main_below_4v7,
   input wire logic       chip_hot,
   input wire logic [1:0] usb_current_limit,
   input wire logic       supply_supervisor_reset_n,
   input wire logic [1:0] usb_switch_on,
   input wire logic [1:0] usb_fault_output_n,
   input wire logic [2:0] buck_on,
   input wire logic [2:0] buck_high_side_enable,
   input wire logic       soft_start_discharge,
   input wire logic       regulator_enable_discharge,
   input wire logic       supply_heat_warning_n
);
   timeunit 1ns;
   timeprecision 100ps;
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   // --------
   // start spacing counter, saturates so idle time never wraps
   // --------
   logic [7:0] gap_q;
   always_ff @(posedge clk or posedge rst) begin
      if (rst) gap_q <= 8'hff;
      else if ($rose(soft_start_discharge)) gap_q <= 8'h00;
      else if (gap_q != 8'hff) gap_q <= gap_q + 8'h01;
   end
   // --------
   // checks
   // --------
   a_reset_holds_low: assert property ($fell(supply_supervisor_reset_n) |=> !supply_supervisor_reset_n [*8])
      else $error("supervisor reset released early");
   a_hot_usb_off: assert property (chip_hot [*4] |=> usb_switch_on == 2'h0)
      else $error("usb switch on while hot");
   a_fault_on_limit: assert property ((usb_current_limit[0] && usb_switch_on[0]) [*4] |=> !usb_fault_output_n[0])
      else $error("fault not shown while limiting");
   a_warn_on_hot: assert property (chip_hot [*4] |=> !supply_heat_warning_n)
      else $error("warning high while hot");
   a_warn_on_brown: assert property (main_below_9v3 [*4] |=> !supply_heat_warning_n)
      else $error("warning high in brownout");
   a_one_start: assert property ($onehot0(buck_on & ~$past(buck_on)))
      else $error("two rails started together");
   a_ramp_first: assert property ((buck_on & ~$past(buck_on)) != 3'h0 |-> $past(soft_start_discharge))
      else $error("rail started without soft start discharge");
   a_start_gap: assert property ($rose(soft_start_discharge) |-> gap_q >= SPACE_CYC + DISCH_CYC - 1)
      else $error("rail starts too close");
   a_lock_bucks: assert property (main_below_4v7 [*4] |=> buck_on == 3'h0 && regulator_enable_discharge)
      else $error("rails on in lockout");
   a_blank_hold: assert property ($fell(buck_high_side_enable[0]) |=> !buck_high_side_enable[0] [*8])
      else $error("blanking shorter than one cycle");
   cover property ($rose(buck_on[2]));
   cover property ($fell(buck_high_side_enable[0]));
   cover property ($rose(regulator_enable_discharge));
endmodule : rail_seq_monitor

bind rail_sequencing_fault_control rail_seq_monitor #(.SPACE_CYC(SPACE_CYC), .DISCH_CYC(DISCH_CYC)) u_rail_seq_monitor (.*);

// *** verif/host_pins_model.sv ***
module host_pins_model
(
   input  wire logic       clk,
   input  wire logic       rst,
   input  wire logic [2:0] pin_req,
   input  wire logic       regulator_enable_discharge,
   output logic      [2:0] regulator_enable_pin
);
   timeunit 1ns;
   timeprecision 100ps;
   // a discharged pin needs a few cycles of ramp before it reads high again
   logic [1:0] charge_q;
   always_ff @(posedge clk or posedge rst) begin
      if (rst) charge_q <= 2'h0;
      else if (regulator_enable_discharge) charge_q <= 2'h0;
      else if (charge_q != 2'h3) charge_q <= charge_q + 2'h1;
   end
   assign regulator_enable_pin = (charge_q == 2'h3) ? pin_req : 3'h0;
endmodule : host_pins_model

// *** verif/tb_rail_sequencing_fault_control.sv ***
module tb_rail_sequencing_fault_control
   import rail_seq_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;
   localparam int unsigned DISCH = 10;
   localparam int unsigned SPACE = 30;
   logic clk = 1'b0, rst = 1'b1, mon_one = 1'b0, mon_two = 1'b0, b93 = 1'b0, a108 = 1'b1, b47 = 1'b0, b425 = 1'b0;
   logic b39 = 1'b0, hot = 1'b0, ser = 1'b0, wr_en = 1'b0, rd_en = 1'b0, rst_n, disch, ediss, warn_n, irq;
   logic [1:0] usb_pin = 2'h0, usb_lim = 2'h0, usb_on, flt_n;
   logic [2:0] pin_req = 3'h0, boc = 3'h0, buv = 3'h0, en_pin, bon, hs;
   logic [3:0] addr = 4'h0;
   logic [7:0] wdat = 8'h00, rdat, rv;
   int seed = 11184, miscompares = 0, compares = 0, i, lowcnt = 0;

   always #50 clk = ~clk;

   rail_sequencing_fault_control #(.RESET_CYC(50), .SPACE_CYC(SPACE), .DISCH_CYC(DISCH), .HICCUP_CYC(40))
   u_rail_sequencing_fault_control (.clk(clk), .rst(rst), .monitor_input_one_low(mon_one),
      .monitor_input_two_low(mon_two), .main_below_9v3(b93), .main_above_10v8(a108), .main_below_4v7(b47),
      .regulator_input_below_4v25(b425), .usb_input_below_3v9(b39), .chip_hot(hot), .serial_mode(ser),
      .usb_enable_pin(usb_pin), .usb_current_limit(usb_lim), .regulator_enable_pin(en_pin),
      .buck_overcurrent(boc), .buck_output_undervoltage(buv), .addr(addr), .wr_data(wdat), .wr_en(wr_en),
      .rd_en(rd_en), .rd_data(rdat), .supply_supervisor_reset_n(rst_n), .usb_switch_on(usb_on),
      .usb_fault_output_n(flt_n), .buck_on(bon), .buck_high_side_enable(hs), .soft_start_discharge(disch),
      .regulator_enable_discharge(ediss), .supply_heat_warning_n(warn_n), .host_irq(irq));
   host_pins_model u_host_pins_model (.clk(clk), .rst(rst), .pin_req(pin_req),
      .regulator_enable_discharge(ediss), .regulator_enable_pin(en_pin));

   // --------
   // helpers
   // --------
   task automatic stop_test();
      $display("compares %0d miscompares %0d", compares, miscompares);
      if (miscompares == 0 && compares > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask : stop_test
   task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
      compares++;
      if (got !== exp) begin
         miscompares++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask : chk
   task automatic step(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : step
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge clk);
      addr  <= a;
      wdat  <= d;
      wr_en <= 1'b1;
      @(posedge clk);
      wr_en <= 1'b0;
   endtask : wr
   task automatic rd(input logic [3:0] a, output logic [7:0] d);
      @(posedge clk);
      addr  <= a;
      rd_en <= 1'b1;
      @(posedge clk);
      rd_en <= 1'b0;
      #1;
      d = rdat;
   endtask : rd
   // waits, bounded, for the rail set to change and compares it
   task automatic wait_bon(input logic [2:0] exp);
      logic [2:0] was;
      int         k;
      was = bon;
      for (k = 0; k < 200 && bon === was; k++) step(1);
      chk("buck_on", exp, bon);
   endtask : wait_bon
   // lowest waiting rail is the next to start
   function automatic logic [2:0] next_on(input logic [2:0] on, input logic [2:0] want);
      logic [2:0] p;
      p = want & ~on;
      return on | (p & (~p + 3'h1));
   endfunction : next_on

   initial begin
      #(20000 * 100);
      miscompares++;
      stop_test();
   end

   // --------
   // scenarios
   // --------
   initial begin
      repeat (5) @(posedge clk);
      rst <= 1'b0;
      step(6);
      chk("warn", 8'h01, warn_n);
      rd(ADDR_STATUS, rv);
      for (i = 0; i < 6; i++) begin
         @(posedge clk) usb_pin <= 2'($random(seed));
         step(5);
         chk("usb pins", {6'h00, usb_pin}, usb_on);
      end
      @(posedge clk) usb_pin <= 2'h3;
      usb_lim <= 2'h1;
      step(7);
      chk("fault", 8'h02, flt_n);
      @(posedge clk) usb_lim <= 2'h0;
      hot <= 1'b1;
      step(5);
      chk("hot usb", 8'h00, usb_on);
      rd(ADDR_STATUS, rv);
      chk("hot flag", 8'h02, rv & 8'h03);
      chk("warn hot", 8'h00, warn_n);
      @(posedge clk) hot <= 1'b0;
      step(5);
      chk("cool usb", 8'h03, usb_on);
      chk("cool warn", 8'h01, warn_n);
      rd(ADDR_STATUS, rv);
      @(posedge clk) b93 <= 1'b1;
      a108 <= 1'b0;
      step(5);
      chk("bor usb", 8'h00, usb_on);
      rd(ADDR_STATUS, rv);
      chk("bor flag", 8'h01, rv & 8'h03);
      @(posedge clk) b93 <= 1'b0;
      step(5);
      chk("bor hyst", 8'h00, warn_n);
      @(posedge clk) a108 <= 1'b1;
      step(5);
      chk("bor end", 8'h01, warn_n);
      @(posedge clk) pin_req <= 3'h4;
      step(4);
      @(posedge clk) pin_req <= 3'h7;
      wait_bon(3'h4);
      step(SPACE);
      chk("spacing", 8'h04, bon);
      wait_bon(next_on(3'h4, 3'h7));
      wait_bon(next_on(3'h5, 3'h7));
      for (i = 0; i < 2; i++) begin
         @(posedge clk) mon_one <= (i == 0);
         mon_two <= (i == 1);
         step(3);
         @(posedge clk) mon_one <= 1'b0;
         mon_two <= 1'b0;
         step(40);
         chk("svs low", 8'h00, rst_n);
         chk("svs rails", 8'h07, bon);
         step(30);
         chk("svs end", 8'h01, rst_n);
      end
      @(posedge clk) boc <= 3'h1;
      for (i = 0; i < 200; i++) begin
         step(1);
         lowcnt += !hs[0];
      end
      chk("blanking", 8'h01, lowcnt inside {[139:140]});
      @(posedge clk) boc <= 3'h0;
      buv <= 3'h1;
      step(5);
      chk("hiccup off", 8'h06, bon);
      @(posedge clk) buv <= 3'h0;
      step(20);
      chk("hiccup hold", 8'h06, bon);
      wait_bon(3'h7);
      for (i = 0; i < 2; i++) begin
         @(posedge clk) b47 <= (i == 0);
         b425 <= (i == 1);
         step(3);
         chk("lock rails", 8'h00, bon);
         chk("lock pins", 8'h01, ediss);
         @(posedge clk) b47 <= 1'b0;
         b425 <= 1'b0;
         wait_bon(next_on(3'h0, 3'h7));
         wait_bon(next_on(3'h1, 3'h7));
         wait_bon(3'h7);
      end
      @(posedge clk) ser <= 1'b1;
      pin_req <= 3'h0;
      step(80);
      wr(ADDR_ENABLE, 8'h0a);
      wait_bon(3'h2);
      chk("ser usb", 8'h02, usb_on);
      rd(ADDR_STATE, rv);
      chk("state", 8'h0a, rv);
      rd(ADDR_STATUS, rv);
      @(posedge clk) b39 <= 1'b1;
      step(5);
      chk("irq", 8'h01, irq);
      @(posedge clk) b39 <= 1'b0;
      rd(ADDR_ENABLE, rv);
      chk("bits cleared", 8'h00, rv);
      rd(4'hf, rv);
      chk("unmapped", 8'h00, rv);
      wr(ADDR_ENABLE, 8'h02);
      step(5);
      chk("usb rewrite", 8'h02, usb_on);
      stop_test();
   end
endmodule : tb_rail_sequencing_fault_control
